// >>> design/wlps_pin_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; a level is taken once stages two and three agree
module wlps_pin_sync #(
   parameter int W = wlps_pkg::PIN_N
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output wire logic [W-1:0] level_out
);

   // All synchroniser state
   typedef struct packed {
      logic [W-1:0] s1;   // Metastable stage, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;  // Accepted level
   } wlps_sync_s;

   wlps_sync_s cur;
   wlps_sync_s next_cur;

   // Shift, and accept a bit only where the later stages agree
   always_comb begin
      next_cur    = cur;
      next_cur.s1 = pin_in;
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;
      for (int i = 0; i < W; i++) begin
         if (cur.s2[i] == cur.s3[i]) begin
            next_cur.lvl[i] = cur.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign level_out = cur.lvl;

   sync_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.lvl != $past(cur.lvl)) |-> ($past(cur.s2) == $past(cur.s3)))
      else $error("level changed without stage agreement");

endmodule // wlps_pin_sync

// >>> design/wlps_pkg.sv
// Shared constants and types of the power-state sequencer
package wlps_pkg;

   // Number of sequenced resources; the fixed sets below are this wide
   localparam int RES_N = 8;
   // Default width of the programmable on and off delays
   localparam int TIMER_W = 8;
   // Width of the core clock rate select
   localparam int RATE_W = 2;
   // Number of pin inputs passed through the synchroniser
   localparam int PIN_N = 3;

   // Resource positions in every set vector
   localparam int RES_BANDGAP   = 0;
   localparam int RES_HV_LDO    = 1;
   localparam int RES_SWITCHER  = 2;
   localparam int RES_CORE_LDO  = 3;
   localparam int RES_XTAL      = 4;
   localparam int RES_PLL       = 5;
   localparam int RES_AFE       = 6;
   localparam int RES_RADIO     = 7;

   // Pin positions in the synchroniser vector
   localparam int PIN_CORE_RST  = 0;
   localparam int PIN_EXT_REQ   = 1;
   localparam int PIN_IO_RAIL   = 2;

   // Fixed resource sets per power mode
   localparam logic [RES_N-1:0] SET_NONE     = 8'h00;
   localparam logic [RES_N-1:0] SET_SHUTDOWN = 8'h03;
   localparam logic [RES_N-1:0] SET_EXTERNAL = 8'h04;
   localparam logic [RES_N-1:0] SET_SLEEP_OFF = 8'hf0;
   localparam logic [RES_N-1:0] SET_ALL      = 8'hff;

   // Clock rate codes and reset values
   localparam logic [RATE_W-1:0] RATE_SLOW   = 2'h0;
   localparam logic [PIN_N-1:0]  PIN_RST_VAL = 3'h0;

   // Power modes of the whole device
   typedef enum logic [2:0] {
      MODE_FULL_PD,
      MODE_SHUTDOWN,
      MODE_EXTERNAL,
      MODE_ACTIVE,
      MODE_SLEEP
   } wlps_mode_e;

   // States of one resource
   typedef enum logic [1:0] {
      RES_DISABLED,
      RES_TURN_ON,
      RES_ENABLED,
      RES_TURN_OFF
   } wlps_res_e;

endpackage

// >>> design/wlps_res_if.sv
`timescale 1ns/100ps
// Link between the sequencer and one resource timer
interface wlps_res_if #(parameter int TW = wlps_pkg::TIMER_W);
   logic                start_on;   // Begin enable sequence
   logic                start_off;  // Begin disable sequence
   logic [TW-1:0]       time_on;    // Programmed enable delay
   logic [TW-1:0]       time_off;   // Programmed disable delay
   wlps_pkg::wlps_res_e st;         // Present resource state
   logic [TW-1:0]       timer;      // Remaining transition time

   // Sequencer side
   modport seq  (output start_on, start_off, time_on, time_off,
                 input  st, timer);
   // Timer side
   modport unit (input  start_on, start_off, time_on, time_off,
                 output st, timer);
endinterface

// >>> design/wlps_resource_timer.sv
`timescale 1ns/100ps
// One resource: four states and a countdown of its on or off delay
module wlps_resource_timer #(
   parameter int TW = wlps_pkg::TIMER_W
) (
   input  wire logic clk,
   input  wire logic rst_n,
   wlps_res_if.unit  port
);

   // All state of one resource
   typedef struct packed {
      wlps_pkg::wlps_res_e st;     // Stable or transition state
      logic [TW-1:0]       timer;  // Zero only in stable states
   } wlps_res_s;

   wlps_res_s cur;
   wlps_res_s next_cur;

   // Load, count down on every sleep clock, settle at zero
   always_comb begin
      next_cur = cur;
      case (cur.st)
         wlps_pkg::RES_DISABLED: begin
            if (port.start_on) begin
               if (port.time_on == '0) begin
                  next_cur.st = wlps_pkg::RES_ENABLED;
               end else begin
                  next_cur.st    = wlps_pkg::RES_TURN_ON;
                  next_cur.timer = port.time_on;
               end
            end
         end
         wlps_pkg::RES_ENABLED: begin
            if (port.start_off) begin
               if (port.time_off == '0) begin
                  next_cur.st = wlps_pkg::RES_DISABLED;
               end else begin
                  next_cur.st    = wlps_pkg::RES_TURN_OFF;
                  next_cur.timer = port.time_off;
               end
            end
         end
         wlps_pkg::RES_TURN_ON, wlps_pkg::RES_TURN_OFF: begin
            next_cur.timer = cur.timer - TW'(1);
            if (cur.timer == TW'(1)) begin
               next_cur.st = (cur.st == wlps_pkg::RES_TURN_ON) ?
                             wlps_pkg::RES_ENABLED : wlps_pkg::RES_DISABLED;
            end
         end
         default: begin
            // Unknown encoding falls back to off
            next_cur = '0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign port.st    = cur.st;
   assign port.timer = cur.timer;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Delayed enable request as seen from a stable off state
   sequence res_launch_on_q;
      cur.st == wlps_pkg::RES_DISABLED && port.start_on &&
      port.time_on != '0;
   endsequence

   // Immediate enable request
   sequence res_instant_on_q;
      cur.st == wlps_pkg::RES_DISABLED && port.start_on &&
      port.time_on == '0;
   endsequence

   timer_load_a: assert property (res_launch_on_q |=>
      cur.st == wlps_pkg::RES_TURN_ON && cur.timer == $past(port.time_on))
      else $error("on delay not loaded");
   instant_on_a: assert property (res_instant_on_q |=>
      cur.st == wlps_pkg::RES_ENABLED)
      else $error("zero delay did not enable at once");
   stable_timer_a: assert property (
      (cur.st == wlps_pkg::RES_ENABLED || cur.st == wlps_pkg::RES_DISABLED)
      == (cur.timer == '0))
      else $error("timer and state disagree");
   countdown_a: assert property (
      (cur.st == wlps_pkg::RES_TURN_OFF && cur.timer > TW'(1)) |=>
      (cur.st == wlps_pkg::RES_TURN_OFF &&
       cur.timer == $past(cur.timer) - TW'(1)))
      else $error("off timer did not count down by one");

endmodule // wlps_resource_timer

// >>> design/wlps_sequencer.sv
`timescale 1ns/100ps
// What this block does
// - Switch resources from need set and delays
// - Ordering comes from programmable tables
// - Sleep-clock counters time each resource switch
// - Gate or slow clocks per mode
// - Active mode: all on, efficient regulator mode
// - Active mode: clock speed follows workload
// - Sleep: radio, front end, PLL, crystal off
// - Sleep: main clocks stopped, sleep clock private
// - Sequencer can wake chip from sleep
// - No I/O rail, both pins low: full off
// - I/O rail present, both pins low: shutdown
// - Shutdown keeps only bandgap and linear regulator
// - Either pin high exits power-down
// - External mode enables only core switcher
// - Four states; timer zero only when stable
// - Timer loads, counts down, zero is immediate
// - Disable unneeded resource without powered dependents
// - Enable needed resource once dependencies enabled; external mode skips the dependency wait
module wlps_sequencer #(
   parameter int TIMER_W = wlps_pkg::TIMER_W
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          wireless_core_reset_low,
   input  wire logic                          external_switcher_request,
   input  wire logic                          io_supply_rail,
   input  wire logic                          sleep_request,
   input  wire logic                          wake_request,
   input  wire logic                          heavy_load,
   input  wire logic [wlps_pkg::RATE_W-1:0]   workload_rate,
   input  wire logic [wlps_pkg::RES_N-1:0][TIMER_W-1:0] time_on_table,
   input  wire logic [wlps_pkg::RES_N-1:0][TIMER_W-1:0] time_off_table,
   input  wire logic [wlps_pkg::RES_N-1:0][wlps_pkg::RES_N-1:0]
                                              dependency_table,
   output wlps_pkg::wlps_mode_e               power_mode,
   output logic [wlps_pkg::RES_N-1:0]         resource_enable,
   output logic [wlps_pkg::RES_N-1:0]         resource_ready,
   output logic [wlps_pkg::RES_N-1:0]         resource_pending,
   output logic                               main_clock_enable,
   output logic [wlps_pkg::RATE_W-1:0]        clock_rate,
   output logic                               switcher_pwm_mode,
   output logic                               sleep_clock_to_core
);

   localparam int N = wlps_pkg::RES_N;

   // Delays must at least hold a one-cycle transition
   if (TIMER_W < 1 || TIMER_W > 16) begin : g_bad_width
      $error("TIMER_W must lie between 1 and 16");
   end

   // All registered state of the sequencer
   typedef struct packed {
      wlps_pkg::wlps_mode_e         mode;     // Present power mode
      logic [wlps_pkg::RATE_W-1:0]  rate;     // Core clock rate select
      logic                         clk_en;   // Main clock gate
      logic                         pwm;      // Switcher in pulse-width mode
      logic                         lp_share; // Sleep clock to core logic
      logic [N-1:0]                 enable;   // Resource powered
      logic [N-1:0]                 ready;    // Resource stable on
      logic [N-1:0]                 pending;  // Resource in transition
   } wlps_top_s;

   wlps_top_s cur;
   wlps_top_s next_cur;

   // Raw and synchronised pin levels
   logic [wlps_pkg::PIN_N-1:0] pins_raw;
   logic [wlps_pkg::PIN_N-1:0] pins_sync;
   logic                       core_run;   // Core out of reset
   logic                       ext_req;    // External switcher wanted
   logic                       io_present; // I/O rail powered

   // Per-resource status gathered from the timers
   wlps_pkg::wlps_res_e [N-1:0] res_st;
   logic [N-1:0] res_ready;     // Stable on
   logic [N-1:0] res_off;       // Stable off
   logic [N-1:0] res_powered;   // Anything but stable off
   logic [N-1:0] res_moving;    // In a transition
   logic [N-1:0] need;          // Required set after dependencies
   logic [N-1:0] has_dependent; // Some powered resource leans on it
   logic [N-1:0] deps_met;      // All dependencies stable on, or external mode
   logic [N-1:0] start_on;
   logic [N-1:0] start_off;

   // Mode test used by the power-down exit check
   function automatic logic is_power_down(wlps_pkg::wlps_mode_e m);
      return (m == wlps_pkg::MODE_FULL_PD) || (m == wlps_pkg::MODE_SHUTDOWN);
   endfunction

   assign pins_raw[wlps_pkg::PIN_CORE_RST] = wireless_core_reset_low;
   assign pins_raw[wlps_pkg::PIN_EXT_REQ]  = external_switcher_request;
   assign pins_raw[wlps_pkg::PIN_IO_RAIL]  = io_supply_rail;

   wlps_pin_sync #(
      .W         (wlps_pkg::PIN_N)
   ) u_pin_sync (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    (pins_raw),
      .level_out (pins_sync)
   );

   assign core_run   = pins_sync[wlps_pkg::PIN_CORE_RST];
   assign ext_req    = pins_sync[wlps_pkg::PIN_EXT_REQ];
   assign io_present = pins_sync[wlps_pkg::PIN_IO_RAIL];

   // One timer per resource, joined by its own link
   for (genvar g = 0; g < N; g++) begin : g_res
      wlps_res_if #(.TW(TIMER_W)) rif ();

      assign rif.start_on  = start_on[g];
      assign rif.start_off = start_off[g];
      assign rif.time_on   = time_on_table[g];
      assign rif.time_off  = time_off_table[g];
      assign res_st[g]     = rif.st;

      wlps_resource_timer #(
         .TW    (TIMER_W)
      ) u_timer (
         .clk   (clk),
         .rst_n (rst_n),
         .port  (rif.unit)
      );

      assign res_ready[g]   = (res_st[g] == wlps_pkg::RES_ENABLED);
      assign res_off[g]     = (res_st[g] == wlps_pkg::RES_DISABLED);
      assign res_powered[g] = !res_off[g];
      assign res_moving[g]  = (res_st[g] == wlps_pkg::RES_TURN_ON) ||
                              (res_st[g] == wlps_pkg::RES_TURN_OFF);
   end

   // Required set per mode, widened through the dependency table
   always_comb begin
      logic [N-1:0] base;
      base = wlps_pkg::SET_NONE;
      case (cur.mode)
         wlps_pkg::MODE_ACTIVE:   base = wlps_pkg::SET_ALL;
         wlps_pkg::MODE_SLEEP:    base = ~wlps_pkg::SET_SLEEP_OFF;
         wlps_pkg::MODE_SHUTDOWN: base = wlps_pkg::SET_SHUTDOWN;
         wlps_pkg::MODE_EXTERNAL: base = wlps_pkg::SET_EXTERNAL;
         default:                 base = wlps_pkg::SET_NONE;
      endcase
      need = base;
      // close the set over dependencies; N passes cover any chain
      for (int k = 0; k < N; k++) begin
         for (int i = 0; i < N; i++) begin
            if (need[i]) begin
               need = need | dependency_table[i];
            end
         end
      end
      // Fixed mode sets win over what the tables would add
      case (cur.mode)
         wlps_pkg::MODE_SLEEP:    need = need & ~wlps_pkg::SET_SLEEP_OFF;
         wlps_pkg::MODE_SHUTDOWN: need = need & wlps_pkg::SET_SHUTDOWN;
         wlps_pkg::MODE_EXTERNAL: need = wlps_pkg::SET_EXTERNAL;
         wlps_pkg::MODE_ACTIVE:   need = need;
         default:                 need = wlps_pkg::SET_NONE;
      endcase
   end

   // Enable and disable decisions for each resource
   always_comb begin
      for (int i = 0; i < N; i++) begin
         has_dependent[i] = 1'b0;
         for (int j = 0; j < N; j++) begin
            if (dependency_table[j][i] && res_powered[j] && j != i) begin
               has_dependent[i] = 1'b1;
            end
         end
         // External mode ignores dependencies so nothing else wakes
         deps_met[i] = (cur.mode == wlps_pkg::MODE_EXTERNAL) ||
                       ((dependency_table[i] & res_ready) ==
                        dependency_table[i]);
         start_on[i]  = res_off[i] && need[i] && deps_met[i];
         start_off[i] = res_ready[i] && !need[i] && !has_dependent[i];
      end
   end

   // Mode selection and registered outputs
   always_comb begin
      next_cur = cur;
      if (!core_run && !ext_req) begin
         next_cur.mode = io_present ? wlps_pkg::MODE_SHUTDOWN :
                                      wlps_pkg::MODE_FULL_PD;
      end else if (!core_run) begin
         next_cur.mode = wlps_pkg::MODE_EXTERNAL;
      end else begin
         case (cur.mode)
            wlps_pkg::MODE_ACTIVE: begin
               // Sleep only when asked and no wake is pending
               if (sleep_request && !wake_request) begin
                  next_cur.mode = wlps_pkg::MODE_SLEEP;
               end
            end
            wlps_pkg::MODE_SLEEP: begin
               if (wake_request) begin
                  next_cur.mode = wlps_pkg::MODE_ACTIVE;
               end
            end
            default: begin
               next_cur.mode = wlps_pkg::MODE_ACTIVE;
            end
         endcase
      end
      next_cur.rate     = (cur.mode == wlps_pkg::MODE_ACTIVE) ?
                          workload_rate : wlps_pkg::RATE_SLOW;
      next_cur.clk_en   = (cur.mode == wlps_pkg::MODE_ACTIVE) &&
                          res_ready[wlps_pkg::RES_PLL];
      next_cur.lp_share = (cur.mode == wlps_pkg::MODE_ACTIVE);
      // pulse-width only under heavy load, burst otherwise
      next_cur.pwm      = heavy_load &&
                          res_powered[wlps_pkg::RES_SWITCHER];
      next_cur.enable   = res_powered;
      next_cur.ready    = res_ready;
      next_cur.pending  = res_moving;
   end

   // State register; reset lands in full power-down
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur      <= '0;
         cur.mode <= wlps_pkg::MODE_FULL_PD;
         cur.rate <= wlps_pkg::RATE_SLOW;
      end else begin
         cur <= next_cur;
      end
   end

   assign power_mode          = cur.mode;
   assign resource_enable     = cur.enable;
   assign resource_ready      = cur.ready;
   assign resource_pending    = cur.pending;
   assign main_clock_enable   = cur.clk_en;
   assign clock_rate          = cur.rate;
   assign switcher_pwm_mode   = cur.pwm;
   assign sleep_clock_to_core = cur.lp_share;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   full_off_a: assert property (!core_run && !ext_req && !io_present |=>
      cur.mode == wlps_pkg::MODE_FULL_PD)
      else $error("full power-down not entered");
   shutdown_a: assert property (!core_run && !ext_req && io_present |=>
      cur.mode == wlps_pkg::MODE_SHUTDOWN)
      else $error("shutdown not entered");
   shutdown_set_a: assert property (
      cur.mode == wlps_pkg::MODE_SHUTDOWN |->
      (need & ~wlps_pkg::SET_SHUTDOWN) == '0 &&
      (start_on & ~wlps_pkg::SET_SHUTDOWN) == '0)
      else $error("extra resource needed in shutdown");
   // external set; start decisions are held to the fixed set
   external_only_a: assert property (
      cur.mode == wlps_pkg::MODE_EXTERNAL |->
      need == wlps_pkg::SET_EXTERNAL &&
      (start_on & ~wlps_pkg::SET_EXTERNAL) == '0)
      else $error("external mode needs more than switcher");
   pd_exit_a: assert property (is_power_down(cur.mode) && core_run |=>
      cur.mode == wlps_pkg::MODE_ACTIVE)
      else $error("power-down not left");
   wake_a: assert property (cur.mode == wlps_pkg::MODE_SLEEP &&
      core_run && wake_request |=> cur.mode == wlps_pkg::MODE_ACTIVE)
      else $error("sleep not woken");
   sleep_clock_a: assert property (cur.mode == wlps_pkg::MODE_SLEEP
      ##1 cur.mode == wlps_pkg::MODE_SLEEP |->
      !main_clock_enable && !sleep_clock_to_core)
      else $error("clock running in sleep");
   dep_order_a: assert property (cur.mode != wlps_pkg::MODE_EXTERNAL |->
      (start_on & ~deps_met) == '0)
      else $error("enable began before dependencies");
   slow_rate_a: assert property (cur.mode != wlps_pkg::MODE_ACTIVE |=>
      clock_rate == wlps_pkg::RATE_SLOW)
      else $error("fast clock rate outside active mode");

endmodule // wlps_sequencer

// >>> tb/wlps_host_model.sv
`timescale 1ns/100ps
// Host side: drives the three pins off the falling edge of the clock
module wlps_host_model (
   input  wire logic clk,
   input  wire logic cmd_rst,
   input  wire logic cmd_ext,
   input  wire logic cmd_io,
   output logic      wireless_core_reset_low,
   output logic      external_switcher_request,
   output logic      io_supply_rail
);
   logic [2:0]       held = 3'h0; // Commands taken at the rising edge

   // Pins start low, the way a host holds the core down at power-up
   initial begin
      wireless_core_reset_low   = 1'b0;
      external_switcher_request = 1'b0;
      io_supply_rail            = 1'b0;
   end

   // Commands are taken on the rising edge, where they stand still, so
   // a one-cycle command gives a one-cycle pin pulse with no race
   always @(posedge clk) begin
      held <= {cmd_io, cmd_ext, cmd_rst};
   end

   // host leaves power-down
   // Pins move only on the falling edge, never on the sampling edge
   always @(negedge clk) begin
      wireless_core_reset_low   <= held[0];
      external_switcher_request <= held[1];
      io_supply_rail            <= held[2];
   end
endmodule // wlps_host_model

// >>> tb/wlps_sequencer_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
   num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
   end end
// Bench for the power-state sequencer
module wlps_sequencer_tb;
   logic                   clk = 1'b0;        // Sleep clock
   logic                   rst_n = 1'b0;      // Sync reset
   logic                   cmd_rst = 1'b0;    // Host command, core reset
   logic                   cmd_ext = 1'b0;    // Host command, switcher
   logic                   cmd_io = 1'b0;     // Host command, I/O rail
   logic                   sleep_request = 1'b0;
   logic                   wake_request = 1'b0;
   logic                   heavy_load = 1'b0;
   logic [1:0]             workload_rate = 2'h0;
   logic [7:0][7:0]        t_on = 64'h0303_0306_0303_0300;
   logic [7:0][7:0]        t_off = 64'h0202_0202_0202_0200;
   logic [7:0][7:0]        deps = 64'h0000_1000_0000_0000; // PLL needs xtal
   wire logic              pin_rst, pin_ext, pin_io;
   wlps_pkg::wlps_mode_e   power_mode;
   logic [7:0]             res_en, res_rdy, res_pend;
   logic                   main_clk_en, pwm_mode, core_sleep_clk;
   logic [1:0]             clock_rate;
   logic [7:0]             seen_pend = 8'h00; // Transitions observed
   int                     num_errors = 0;
   int                     n_tests = 0;

   // 40 ns period
   always #20 clk = ~clk;

   wlps_host_model u_wlps_host_model (.clk(clk), .cmd_rst(cmd_rst),
      .cmd_ext(cmd_ext), .cmd_io(cmd_io),
      .wireless_core_reset_low(pin_rst),
      .external_switcher_request(pin_ext), .io_supply_rail(pin_io));

   wlps_sequencer u_wlps_sequencer (.clk(clk), .rst_n(rst_n),
      .wireless_core_reset_low(pin_rst),
      .external_switcher_request(pin_ext), .io_supply_rail(pin_io),
      .sleep_request(sleep_request), .wake_request(wake_request),
      .heavy_load(heavy_load), .workload_rate(workload_rate),
      .time_on_table(t_on), .time_off_table(t_off),
      .dependency_table(deps), .power_mode(power_mode),
      .resource_enable(res_en), .resource_ready(res_rdy),
      .resource_pending(res_pend), .main_clock_enable(main_clk_en),
      .clock_rate(clock_rate), .switcher_pwm_mode(pwm_mode),
      .sleep_clock_to_core(core_sleep_clk));

   // Ongoing checks on resource states; run every cycle out of reset
   always @(negedge clk) begin
      if (rst_n) begin
         seen_pend <= seen_pend | res_pend;
         `CHK(res_pend & res_rdy, 8'h00)
         `CHK(res_pend[0], 1'b0)
         `CHK(res_rdy[5] & ~res_rdy[4], 1'b0)
         `CHK(res_en[5] & ~res_en[4], 1'b0)
      end
   end

   // Prints the counts and the verdict, then stops
   task automatic print_verdict();
      $display("tests=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Waits, bounded, for a mode and ready set, then compares both
   task automatic settle(input wlps_pkg::wlps_mode_e m,
                         input logic [7:0] r);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge clk);
         // Ready alone drops at the start of a turn-off, so also wait
         // until no resource is still in a transition
         if (power_mode === m && res_rdy === r && res_pend === 8'h00)
            break;
      end
      if (i == 300) begin
         num_errors++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, res_rdy, r);
         print_verdict();
      end
      `CHK(power_mode, m)
      `CHK(res_rdy, r)
   endtask

   // Main sequence: walk every power mode through the host pins
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK(power_mode, wlps_pkg::MODE_FULL_PD)
      `CHK(res_en, wlps_pkg::SET_NONE)
      cmd_io = 1'b1;
      settle(wlps_pkg::MODE_SHUTDOWN, wlps_pkg::SET_SHUTDOWN);
      $display("test shutdown done");
      cmd_ext = 1'b1;
      settle(wlps_pkg::MODE_EXTERNAL, wlps_pkg::SET_EXTERNAL);
      $display("test external done");
      cmd_rst = 1'b1;
      settle(wlps_pkg::MODE_ACTIVE, wlps_pkg::SET_ALL);
      `CHK(main_clk_en, 1'b1)
      `CHK(core_sleep_clk, 1'b1)
      // Every rate code, load level toggled alongside
      for (int r = 0; r < 4; r++) begin
         workload_rate = 2'(r);
         heavy_load = r[0];
         repeat (3) @(negedge clk);
         `CHK(clock_rate, 2'(r))
         `CHK(pwm_mode, r[0])
      end
      $display("test active done");
      // A one-cycle dip on the reset pin must not be taken
      cmd_rst = 1'b0;
      @(negedge clk);
      cmd_rst = 1'b1;
      repeat (8) begin
         @(negedge clk);
         `CHK(power_mode, wlps_pkg::MODE_ACTIVE)
      end
      $display("test glitch done");
      sleep_request = 1'b1;
      settle(wlps_pkg::MODE_SLEEP, ~wlps_pkg::SET_SLEEP_OFF);
      `CHK(main_clk_en, 1'b0)
      `CHK(clock_rate, wlps_pkg::RATE_SLOW)
      `CHK(core_sleep_clk, 1'b0)
      $display("test sleep done");
      // Wake wins while sleep is still asked for
      wake_request = 1'b1;
      settle(wlps_pkg::MODE_ACTIVE, wlps_pkg::SET_ALL);
      sleep_request = 1'b0;
      wake_request = 1'b0;
      $display("test wake done");
      {cmd_io, cmd_rst, cmd_ext} = 3'h0;
      settle(wlps_pkg::MODE_FULL_PD, wlps_pkg::SET_NONE);
      `CHK(res_en, wlps_pkg::SET_NONE)
      `CHK(seen_pend[7], 1'b1)
      $display("test power-down done");
      print_verdict();
   end
endmodule // wlps_sequencer_tb
